//--- rtl/dlg_regs.sv
// Load policy and pin configuration registers with DAC input/output stores
//
// Behaviour
// - Policy 00: a channel input write also loads its DAC register at once.
// - Policy 01: channel writes update input registers only; outputs hold.
// - Writing policy 10 copies all input registers to DAC registers together.
// - Policy field is bits 1:0, read/write, resets to zero.
// - Output-select bit n set makes pin n a general-purpose output.
// - A cleared select bit has no effect; other registers decide.
// - Drive-level bit n sets output pin high (1) or low (0).
// - Input-select bit n set makes pin n a general-purpose input.
// - Bits 15:8 of pin registers read zero, ignore writes, reset 0x0000.
// - Analog-output select bit n makes pin n a DAC output.
`timescale 1ns/1ps
`default_nettype none
`include "dlg_params.svh"

module dlg_regs #(
  parameter int CHANNELS = 8,
  parameter int CODE_W   = 12
) (
  input  wire logic                  clk_i,          // System clock
  input  wire logic                  rst_i,          // Async reset, high
  input  wire logic                  reg_wr_i,       // Register write strobe
  input  wire logic                  reg_rd_i,       // Register read strobe
  input  wire logic [`DLG_PTR_W-1:0] reg_ptr_i,      // Register pointer
  input  wire logic [15:0]           reg_wdata_i,    // Register write data
  output logic      [15:0]           reg_rdata_o,    // Read data, registered
  output logic                       reg_rvalid_o,   // Read data valid pulse
  input  wire logic                  dac_wr_i,       // Channel input write
  input  wire logic [2:0]            dac_ch_i,       // Channel number
  input  wire logic [CODE_W-1:0]     dac_data_i,     // Channel code
  output logic [CHANNELS*CODE_W-1:0] dac_value_o,    // DAC registers, flat
  output logic [CHANNELS*CODE_W-1:0] dac_input_o,    // Input registers, flat
  output logic                       load_converter_strobe_o, // Outputs moved
  output logic [CHANNELS-1:0]        dac_pin_en_o,   // Pin is DAC output
  output logic [CHANNELS-1:0]        gpio_oe_o,      // Pin driven as output
  output logic [CHANNELS-1:0]        gpio_out_o,     // Pin drive level
  output logic [CHANNELS-1:0]        gpio_ie_o       // Pin sampled as input
);

  // Register file state
  dlg_pkg::dlg_policy_t policy_q;
  logic [CHANNELS-1:0]  dac_sel_q;
  logic [CHANNELS-1:0]  out_sel_q;
  logic [CHANNELS-1:0]  drive_q;
  logic [CHANNELS-1:0]  in_sel_q;
  logic [CODE_W-1:0]    input_q [CHANNELS];
  logic [CODE_W-1:0]    dac_q   [CHANNELS];
  logic                 strobe_q;
  logic [15:0]          rdata_q;
  logic                 rvalid_q;

  // Address decode of the register pointer
  wire logic wr_policy  = reg_wr_i && (reg_ptr_i == `DLG_PTR_POLICY);
  wire logic wr_dac_sel = reg_wr_i && (reg_ptr_i == `DLG_PTR_DAC_SEL);
  wire logic wr_out_sel = reg_wr_i && (reg_ptr_i == `DLG_PTR_OUT_SEL);
  wire logic wr_drive   = reg_wr_i && (reg_ptr_i == `DLG_PTR_DRIVE);
  wire logic wr_in_sel  = reg_wr_i && (reg_ptr_i == `DLG_PTR_IN_SEL);

  // Load decisions; codes 01 and 11 both fall into hold
  wire logic xfer_all  = wr_policy &&
    (reg_wdata_i[`DLG_POLICY_MSB:`DLG_POLICY_LSB] == `DLG_POL_ALL_AT_ONCE);
  wire logic immediate = dac_wr_i && (policy_q == `DLG_POL_IMMEDIATE);
  wire logic dac_moves = xfer_all || immediate;

  // Read mux; upper bits stay zero so reserved fields read back clean
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = `DLG_RST_WORD;
    case (reg_ptr_i)
      `DLG_PTR_POLICY:  rd_mux[`DLG_POLICY_MSB:`DLG_POLICY_LSB] = policy_q;
      `DLG_PTR_DAC_SEL: rd_mux[`DLG_PIN_MSB:0] = dac_sel_q;
      `DLG_PTR_OUT_SEL: rd_mux[`DLG_PIN_MSB:0] = out_sel_q;
      `DLG_PTR_DRIVE:   rd_mux[`DLG_PIN_MSB:0] = drive_q;
      `DLG_PTR_IN_SEL:  rd_mux[`DLG_PIN_MSB:0] = in_sel_q;
      default:          rd_mux = `DLG_RST_WORD;
    endcase
  end

  // Configuration registers; pin registers store only bits 7:0 and policy only bits 1:0, the rest are dropped
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      policy_q  <= `DLG_RST_POLICY;
      dac_sel_q <= `DLG_RST_PINS;
      out_sel_q <= `DLG_RST_PINS;
      drive_q   <= `DLG_RST_PINS;
      in_sel_q  <= `DLG_RST_PINS;
    end else begin
      if (wr_policy)
        policy_q <= reg_wdata_i[`DLG_POLICY_MSB:`DLG_POLICY_LSB];
      if (wr_dac_sel)
        dac_sel_q <= reg_wdata_i[`DLG_PIN_MSB:0];
      if (wr_out_sel)
        out_sel_q <= reg_wdata_i[`DLG_PIN_MSB:0];
      if (wr_drive)
        drive_q <= reg_wdata_i[`DLG_PIN_MSB:0];
      if (wr_in_sel)
        in_sel_q <= reg_wdata_i[`DLG_PIN_MSB:0];
    end
  end

  // Registered read port, one cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q  <= `DLG_RST_WORD;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_i;
      if (reg_rd_i)
        rdata_q <= rd_mux;
    end
  end

  // Strobe marks the cycle after any DAC register update
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      strobe_q <= 1'b0;
    else
      strobe_q <= dac_moves;
  end

  // Per-channel input and DAC registers
  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    // Size cast keeps the genvar compare legal where part-selects are not
    wire logic hit = dac_wr_i && (dac_ch_i == 3'(c));
    // A transfer takes the old input value even if the same channel
    // is written in that cycle; the fresh code waits for the next load
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        input_q[c] <= '0;
        dac_q[c]   <= '0;
      end else begin
        if (hit)
          input_q[c] <= dac_data_i;
        if (xfer_all)
          dac_q[c] <= input_q[c];
        else if (hit && immediate)
          dac_q[c] <= dac_data_i;
      end
    end
    assign dac_value_o[c*CODE_W +: CODE_W] = dac_q[c];
    assign dac_input_o[c*CODE_W +: CODE_W] = input_q[c];
  end

  // Pin function outputs; a cleared bit simply asserts nothing here
  assign dac_pin_en_o = dac_sel_q;
  assign gpio_oe_o    = out_sel_q;
  assign gpio_out_o   = drive_q;
  assign gpio_ie_o    = in_sel_q;
  assign load_converter_strobe_o = strobe_q;
  assign reg_rdata_o  = rdata_q;
  assign reg_rvalid_o = rvalid_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_imm_write;
    policy_q == `DLG_POL_IMMEDIATE && dac_wr_i && !wr_policy;
  endsequence

  property p_imm_load;
    s_imm_write |=> dac_q[$past(dac_ch_i)] == $past(dac_data_i)
                    ##0 load_converter_strobe_o;
  endproperty
  a_imm_load: assert property (p_imm_load)
    else $error("immediate policy did not load the DAC register");

  property p_hold;
    policy_q != `DLG_POL_IMMEDIATE && !xfer_all |=> $stable(dac_value_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("DAC registers moved while held");

  property p_xfer;
    xfer_all |=> dac_value_o == $past(dac_input_o) && load_converter_strobe_o;
  endproperty
  a_xfer: assert property (p_xfer)
    else $error("simultaneous transfer did not copy all inputs");

  property p_policy_wr;
    wr_policy |=>
      policy_q == $past(reg_wdata_i[`DLG_POLICY_MSB:`DLG_POLICY_LSB]);
  endproperty
  a_policy_wr: assert property (p_policy_wr)
    else $error("policy field did not take the written value");

  property p_keep_all;
    xfer_all ##1 !wr_policy [*2] |=> policy_q == `DLG_POL_ALL_AT_ONCE;
  endproperty
  a_keep_all: assert property (p_keep_all)
    else $error("all-at-once code not retained");

  property p_out_sel;
    wr_out_sel |=> gpio_oe_o == $past(reg_wdata_i[7:0]);
  endproperty
  a_out_sel: assert property (p_out_sel)
    else $error("output select not applied");

  property p_drive;
    wr_drive |=> gpio_out_o == $past(reg_wdata_i[7:0]);
  endproperty
  a_drive: assert property (p_drive)
    else $error("drive level not applied");

  property p_in_sel;
    wr_in_sel |=> gpio_ie_o == $past(reg_wdata_i[7:0]);
  endproperty
  a_in_sel: assert property (p_in_sel)
    else $error("input select not applied");

  property p_resv;
    reg_rd_i && reg_ptr_i inside {`DLG_PTR_OUT_SEL, `DLG_PTR_DRIVE,
                                  `DLG_PTR_IN_SEL}
      |=> reg_rvalid_o && reg_rdata_o[15:8] == 8'h00;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved bits read non-zero");

  property p_dac_sel;
    wr_dac_sel |=> dac_pin_en_o == $past(reg_wdata_i[7:0]);
  endproperty
  a_dac_sel: assert property (p_dac_sel)
    else $error("analog output select not applied");

endmodule // dlg_regs
`default_nettype wire

//--- rtl/dlg_params.svh
// Register pointers, field positions, reset values and encodings
`ifndef DLG_PARAMS_SVH
`define DLG_PARAMS_SVH

`define DLG_PTR_W          4
`define DLG_PTR_DAC_SEL    4'h5
`define DLG_PTR_POLICY     4'h7
`define DLG_PTR_OUT_SEL    4'h8
`define DLG_PTR_DRIVE      4'h9
`define DLG_PTR_IN_SEL     4'ha

`define DLG_POLICY_LSB     0
`define DLG_POLICY_MSB     1
`define DLG_PIN_MSB        7

`define DLG_RST_WORD       16'h0000
`define DLG_RST_PINS       8'h00
`define DLG_RST_POLICY     2'h0

`define DLG_POL_IMMEDIATE  2'h0
`define DLG_POL_HOLD       2'h1
`define DLG_POL_ALL_AT_ONCE 2'h2

`endif

//--- rtl/dlg_pkg.sv
// Shared types of the load policy and pin configuration register bank
package dlg_pkg;
  typedef logic [15:0] dlg_word_t;
  typedef logic [1:0]  dlg_policy_t;
  typedef logic [7:0]  dlg_pins_t;
  typedef logic [2:0]  dlg_chan_t;
  typedef logic [11:0] dlg_code_t;
endpackage

//--- test/dlg_host.sv
// Host model that drives register and channel write strobes
`timescale 1ns/1ps
`default_nettype none
module dlg_host (
  input  wire logic        clk_i,    // System clock
  input  wire logic [15:0] rdata_i,  // Read data
  input  wire logic        rvalid_i, // Read data valid
  output logic             wr_o,     // Register write strobe
  output logic             rd_o,     // Register read strobe
  output logic [3:0]       ptr_o,    // Register pointer
  output logic [15:0]      wdata_o,  // Register write data
  output logic             cw_o,     // Channel write strobe
  output logic [2:0]       ch_o,     // Channel number
  output logic [11:0]      code_o    // Channel code
);
  // Idle at time zero; every request is a one-cycle pulse off the falling edge
  initial begin
    {wr_o, rd_o, cw_o, ptr_o, wdata_o, ch_o, code_o} = '0;
  end
  // Data is inverted after each request so nothing stale passes for new
  task automatic wr(input logic [3:0] p, input logic [15:0] d);
    @(negedge clk_i);
    {wr_o, ptr_o, wdata_o} = {1'b1, p, d};
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  // Answer is taken half a cycle after the taking edge, in the valid cycle
  task automatic rd(input logic [3:0] p, output logic [15:0] d,
                    output logic v);
    @(negedge clk_i);
    {rd_o, ptr_o} = {1'b1, p};
    @(negedge clk_i);
    rd_o = 1'b0;
    d = rdata_i;
    v = rvalid_i;
  endtask
  task automatic chw(input logic [2:0] c, input logic [11:0] d);
    @(negedge clk_i);
    {cw_o, ch_o, code_o} = {1'b1, c, d};
    @(negedge clk_i);
    cw_o = 1'b0;
    code_o = ~d;
  endtask
endmodule // dlg_host
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the load policy and pin configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "dlg_params.svh"
module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wr, rd, rvalid, cw, strobe;
  logic [3:0]  ptr;
  logic [15:0] wdata, rdata, d;
  logic [2:0]  ch;
  logic [11:0] code;
  logic [95:0] dval, dinp;
  logic [7:0]  pen, oe, lvl, ie;
  logic [11:0] e_in [8];
  logic [11:0] e_val [8];
  logic [1:0]  pol;
  int          fails = 0;
  int          comparisons = 0;
  int          seed = 32'hef0c5a93;
  int          cyc = 0;
  always #4 clk_i = ~clk_i;
  dlg_host dlg_host_inst (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .wr_o(wr), .rd_o(rd), .ptr_o(ptr), .wdata_o(wdata), .cw_o(cw),
    .ch_o(ch), .code_o(code));
  dlg_regs dlg_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_ptr_i(ptr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .dac_wr_i(cw),
    .dac_ch_i(ch), .dac_data_i(code), .dac_value_o(dval),
    .dac_input_o(dinp), .load_converter_strobe_o(strobe),
    .dac_pin_en_o(pen), .gpio_oe_o(oe), .gpio_out_o(lvl), .gpio_ie_o(ie));
  // Expected flat channel image, input side or DAC side
  function automatic logic [95:0] pack(input logic inp);
    for (int i = 0; i < 8; i++) pack[i*12 +: 12] = inp ? e_in[i] : e_val[i];
  endfunction
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] p, input logic [15:0] exp);
    logic [15:0] g;
    logic        v;
    dlg_host_inst.rd(p, g, v);
    chk(v, 1'b1);
    chk(g, exp);
  endtask
  task automatic dac_chk(input logic s);
    chk(dinp, pack(1'b1));
    chk(dval, pack(1'b0));
    chk(strobe, s);
  endtask
  // Upper policy bits are random so dropped bits are exercised too
  task automatic setpol(input logic [1:0] p);
    d = 16'($random(seed));
    d[1:0] = p;
    dlg_host_inst.wr(`DLG_PTR_POLICY, d);
    pol = p;
    if (p == 2'h2) foreach (e_val[i]) e_val[i] = e_in[i];
    dac_chk(p == 2'h2);
    rchk(`DLG_PTR_POLICY, {14'h0000, p});
  endtask
  task automatic cw_rand();
    logic [2:0]  c;
    logic [11:0] v;
    c = 3'($random(seed));
    v = 12'($random(seed));
    dlg_host_inst.chw(c, v);
    e_in[c] = v;
    if (pol == 2'h0) e_val[c] = v;
    dac_chk(pol == 2'h0);
  endtask
  task automatic end_sim;
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Cuts a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    logic [3:0]  ptrs [6];
    logic [15:0] w [4];
    ptrs = '{`DLG_PTR_DAC_SEL, `DLG_PTR_POLICY, `DLG_PTR_OUT_SEL,
             `DLG_PTR_DRIVE, `DLG_PTR_IN_SEL, 4'h3};
    foreach (e_in[i]) {e_in[i], e_val[i]} = 24'h000000;
    pol = 2'h0;
    repeat (16) @(posedge clk_i);
    @(negedge clk_i) rst_i = 1'b0;
    foreach (ptrs[i]) rchk(ptrs[i], 16'h0000);
    // Last round clears every bit, so cleared selects must release pins
    for (int r = 0; r < 4; r++) begin
      foreach (w[k]) w[k] = (r == 3) ? 16'h0000 : 16'($random(seed));
      foreach (w[k]) dlg_host_inst.wr(ptrs[k == 0 ? 0 : k + 1], w[k]);
      // Unmapped pointer write must alias onto no register
      dlg_host_inst.wr(ptrs[5], ~w[0]);
      rchk(ptrs[5], 16'h0000);
      foreach (w[k]) rchk(ptrs[k == 0 ? 0 : k + 1], {8'h00, w[k][7:0]});
      chk({pen, oe, lvl, ie}, {w[0][7:0], w[1][7:0], w[2][7:0], w[3][7:0]});
    end
    cw_rand();
    setpol(2'h1);
    repeat (3) cw_rand();
    setpol(2'h3);
    repeat (3) cw_rand();
    setpol(2'h2);
    repeat (3) cw_rand();
    setpol(2'h2);
    setpol(2'h0);
    repeat (3) cw_rand();
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
